// ### design/omm_pkg.sv
// Constants, register layout and state encoding of the optical module management block.
// Assumes a single 20 MHz clock and an Avalon-MM register bus with byte addresses.
//
// Behaviour
// [R1] Answer serial bus only while select low
// [R2] Drive active-low interrupt on important condition
// [R3] Transmit disable input switches laser off
// [R4] Presence line grounded inside the module
// [R5] Power-down high keeps module in standby
// [R6] Power-down falling edge fully resets module
// [R7] Status and serial lines are open collector
// [R8] Host alone drives the serial clock
// [R9] Sample on clock rise; skip write-protected bytes
// [R10] Change driven serial data on clock fall
// [R11] Host makes start and stop conditions
// [R12] Byte memory, random and auto-increment access
// [R13] Monitor five parameters, readable over serial
// [R14] Flag alarms and warnings outside set range
// [R15] Provide receiver loss-of-signal indicator output
// [R16] Loss-of-signal low normal, high when lost
// [R17] Laser off within 10 us of disable
// [R18] Not-ready held until initialisation completes
package omm_pkg;
    // Timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int TXOFF_MAX_NS = 10000;
    localparam int TXOFF_RAW_CYC = TXOFF_MAX_NS / CLK_PERIOD_NS;
    localparam int TXOFF_MAX_CYC = (TXOFF_RAW_CYC < 1) ? 1 : TXOFF_RAW_CYC;
    localparam int INIT_DEFAULT_CYC = 64;
    // Serial slave address, value arbitrary
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h50;
    // Avalon byte offsets
    localparam logic [5:0] OFS_CTRL = 6'h00;
    localparam logic [5:0] OFS_STATUS = 6'h04;
    localparam logic [5:0] OFS_MASK = 6'h08;
    localparam logic [5:0] OFS_STATE = 6'h0c;
    localparam logic [5:0] OFS_THR0 = 6'h10;
    localparam logic [5:0] OFS_THR_LAST = 6'h20;
    // Control register: write-protect limit in low byte
    localparam int CTRL_WPL_LSB = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0080;
    // Status and mask layout
    localparam int ST_ALARM_LSB = 0;
    localparam int ST_WARN_LSB = 5;
    localparam int ST_LOS_BIT = 10;
    localparam int ST_TXOFF_BIT = 11;
    localparam int ST_WIDTH = 12;
    // Threshold fields and reset value
    localparam int THR_ALO_LSB = 0;
    localparam int THR_WLO_LSB = 8;
    localparam int THR_WHI_LSB = 16;
    localparam int THR_AHI_LSB = 24;
    localparam logic [31:0] THR_RESET = 32'hffff_0000;
    // State register layout
    localparam int STB_STANDBY = 0;
    localparam int STB_NR = 1;
    localparam int STB_LOS = 2;
    localparam int STB_LASER = 3;
    localparam int STB_SEL = 4;
    localparam int STB_PTR_LSB = 8;
    // Serial memory map
    localparam int NUM_MON = 5;
    localparam int MEM_DEPTH = 256;
    localparam logic [7:0] MAP_MON_BASE = 8'h60;
    localparam logic [7:0] MAP_ALARM = 8'h65;
    localparam logic [7:0] MAP_WARN = 8'h66;
    // Serial slave states
    typedef enum logic [7:0] {
        OMM_IDLE = 8'h01,
        OMM_DEV = 8'h02,
        OMM_ACKD = 8'h04,
        OMM_WADR = 8'h08,
        OMM_WDAT = 8'h10,
        OMM_ACKW = 8'h20,
        OMM_RDAT = 8'h40,
        OMM_RACK = 8'h80
    } omm_i2c_state_e;
endpackage : omm_pkg

// ### design/omm_core.sv
// Management logic of the optical module: serial slave, monitors, flags and pins.
// Assumes pins arrive asynchronously and monitor samples come from logic on clk.
//
// Chosen here: the address map and register access over Avalon-MM.
`timescale 1ns/100ps
module omm_core #(
    parameter logic [6:0] DEV_ADDR = omm_pkg::DEV_ADDR_DEFAULT,
    parameter int INIT_CYC = omm_pkg::INIT_DEFAULT_CYC
) (
    input wire logic clk, // 20 MHz clock
    input wire logic reset, // Synchronous reset, high
    input wire logic [5:0] avs_address, // Byte address
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [31:0] avs_writedata, // Write data
    input wire logic [3:0] avs_byteenable, // Byte lanes
    output logic [31:0] avs_readdata, // Read data
    output logic avs_waitrequest, // Stall
    output logic irq, // Level interrupt
    input wire logic scl_i, // Serial clock pin
    input wire logic sda_i, // Serial data pin in
    output logic sda_o, // Serial data out, always low
    output logic sda_oe, // Serial data pull-down
    input wire logic mod_desel_n, // Module select, low active
    input wire logic laser_off_request, // Transmit disable pin
    input wire logic pdown_rst, // Power-down and reset pin
    input wire logic rx_no_light, // Optical detector, high when dark
    input wire logic [7:0] mon_temp, // Temperature sample
    input wire logic [7:0] mon_bias, // Laser bias sample
    input wire logic [7:0] mon_txpwr, // Transmit power sample
    input wire logic [7:0] mon_rxpwr, // Receive power sample
    input wire logic [7:0] mon_vcc, // Supply voltage sample
    output logic laser_enable, // Laser drive on
    output logic standby, // Low-power mode
    output logic int_n_o, // Interrupt pin out
    output logic int_n_oe, // Interrupt pin pull-down
    output logic presence_o, // Presence pin out
    output logic presence_oe, // Presence pin pull-down
    output logic not_ready_flag_o, // Not-ready pin out
    output logic not_ready_flag_oe, // Not-ready pin pull-down
    output logic rx_signal_lost_o, // Loss-of-signal pin out
    output logic rx_signal_lost_oe // Loss-of-signal pin pull-down
);
    import omm_pkg::*;

    localparam int TXOFF_BOUND = TXOFF_MAX_CYC;

    // Refuse an initialisation count the counter cannot serve
    if (INIT_CYC < 1 || INIT_CYC > 65535) begin : g_bad_init
        $error("INIT_CYC must lie in 1..65535");
    end

    // Lane merge for byte enables
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // Range check against one threshold word: {alarm, warning}
    function automatic logic [1:0] range_chk(input logic [7:0] v, input logic [31:0] thr);
        logic al;
        logic wn;
        al = (v < thr[THR_ALO_LSB +: 8]) || (v > thr[THR_AHI_LSB +: 8]);
        wn = (v < thr[THR_WLO_LSB +: 8]) || (v > thr[THR_WHI_LSB +: 8]);
        return {al, wn};
    endfunction : range_chk

    // Pin synchronisers: scl, sda, desel, txdis, pdown, los
    logic [5:0] pin_s1_reg;
    logic [5:0] pin_s2_reg;
    logic [2:0] pin_d_reg;
    wire [5:0] pin_raw = {rx_no_light, pdown_rst, laser_off_request, mod_desel_n, sda_i, scl_i};
    wire scl_s = pin_s2_reg[0];
    wire sda_s = pin_s2_reg[1];
    wire desel_s = pin_s2_reg[2];
    wire txdis_s = pin_s2_reg[3];
    wire pd_s = pin_s2_reg[4];
    wire los_s = pin_s2_reg[5];
    always_ff @(posedge clk) begin
        if (reset) begin
            pin_s1_reg <= 6'h0f;
            pin_s2_reg <= 6'h0f;
            pin_d_reg <= 3'h3;
        end else begin
            pin_s1_reg <= pin_raw;
            pin_s2_reg <= pin_s1_reg;
            pin_d_reg <= {pd_s, sda_s, scl_s};
        end
    end

    // Edge and condition decode on the synchronised pins
    wire scl_rise = scl_s && !pin_d_reg[0]; // see [R9] [R8]
    wire scl_fall = !scl_s && pin_d_reg[0]; // see [R10]
    wire i2c_start = scl_s && pin_d_reg[0] && pin_d_reg[1] && !sda_s; // see [R11]
    wire i2c_stop = scl_s && pin_d_reg[0] && !pin_d_reg[1] && sda_s;
    wire pd_fall = pin_d_reg[2] && !pd_s;

    // Power-down falling edge restarts the core; memory and pin synchronisers are not reset
    logic pd_fall_reg;
    always_ff @(posedge clk) begin
        if (reset) begin
            pd_fall_reg <= 1'b0;
        end else begin
            pd_fall_reg <= pd_fall; // see [R6]
        end
    end
    wire core_rst = reset || pd_fall_reg; // see [R6]

    // Initialisation counter
    logic [15:0] init_cnt_reg;
    wire init_done = (init_cnt_reg == 16'(INIT_CYC));
    always_ff @(posedge clk) begin
        if (core_rst) begin
            init_cnt_reg <= 16'h0000;
        end else if (!init_done) begin
            init_cnt_reg <= init_cnt_reg + 16'h0001; // see [R18]
        end
    end

    // Software registers
    logic [31:0] ctrl_reg;
    logic [ST_WIDTH-1:0] status_reg;
    logic [ST_WIDTH-1:0] mask_reg;
    logic [31:0] thr_reg [NUM_MON];
    logic wait_reg;
    logic [31:0] rdata_reg;
    logic irq_reg;
    wire [7:0] wp_limit = ctrl_reg[CTRL_WPL_LSB +: 8];

    // Monitors and range flags
    wire [7:0] mon [NUM_MON];
    logic [NUM_MON-1:0] alarm_w;
    logic [NUM_MON-1:0] warn_w;
    assign mon[0] = mon_temp; // see [R13]
    assign mon[1] = mon_bias;
    assign mon[2] = mon_txpwr;
    assign mon[3] = mon_rxpwr;
    assign mon[4] = mon_vcc;
    for (genvar g = 0; g < NUM_MON; g++) begin : g_chk
        assign {alarm_w[g], warn_w[g]} = range_chk(mon[g], thr_reg[g]); // see [R14]
    end

    // Bus decode
    wire bus_hit = (avs_read || avs_write) && !wait_reg;
    wire wr_go = avs_write && !wait_reg;
    wire is_thr = (avs_address >= OFS_THR0) && (avs_address <= OFS_THR_LAST) && (avs_address[1:0] == 2'b00);
    wire [2:0] thr_idx = 3'((avs_address - OFS_THR0) >> 2);
    wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}},
                           {8{avs_byteenable[0]}}};
    wire [ST_WIDTH-1:0] st_clr = (wr_go && avs_address == OFS_STATUS) ?
                                 ST_WIDTH'(avs_writedata & be_mask) : '0;
    wire [ST_WIDTH-1:0] st_evt = {txdis_s, los_s, warn_w, alarm_w};
    wire [ST_WIDTH-1:0] status_next = (status_reg & ~st_clr) | st_evt;

    // Serial slave registers
    omm_i2c_state_e st_reg;
    logic [3:0] cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] tx_reg;
    logic [7:0] ptr_reg;
    logic rw_reg;
    logic sda_oe_reg;
    logic [7:0] mem [MEM_DEPTH];

    wire [31:0] state_word = {16'h0000, ptr_reg, 3'b000, !desel_s, laser_enable, los_s, !init_done, standby};
    wire [31:0] rd_mux = (avs_address == OFS_CTRL) ? ctrl_reg :
                         (avs_address == OFS_STATUS) ? 32'(status_reg) :
                         (avs_address == OFS_MASK) ? 32'(mask_reg) :
                         (avs_address == OFS_STATE) ? state_word :
                         is_thr ? thr_reg[thr_idx] : 32'h0000_0000;

    // Bus slave: one stall cycle, then a single answer cycle
    always_ff @(posedge clk) begin
        if (core_rst) begin
            wait_reg <= 1'b1;
            rdata_reg <= 32'h0000_0000;
        end else begin
            wait_reg <= !((avs_read || avs_write) && wait_reg);
            rdata_reg <= (avs_read && wait_reg) ? rd_mux : rdata_reg;
        end
    end

    // Register writes and sticky status
    always_ff @(posedge clk) begin
        if (core_rst) begin
            ctrl_reg <= CTRL_RESET;
            mask_reg <= '0;
            status_reg <= '0;
            irq_reg <= 1'b0;
            for (int i = 0; i < NUM_MON; i++) begin
                thr_reg[i] <= THR_RESET;
            end
        end else begin
            status_reg <= status_next; // see [R2]
            irq_reg <= |(status_reg & mask_reg);
            if (wr_go && avs_address == OFS_CTRL) begin
                ctrl_reg <= merge(ctrl_reg, avs_writedata, avs_byteenable);
            end
            if (wr_go && avs_address == OFS_MASK) begin
                mask_reg <= ST_WIDTH'(merge(32'(mask_reg), avs_writedata, avs_byteenable));
            end
            if (wr_go && is_thr) begin
                thr_reg[thr_idx] <= merge(thr_reg[thr_idx], avs_writedata, avs_byteenable);
            end
        end
    end

    // Byte presented to the serial master: live monitors, flags or memory
    wire [7:0] mon_ofs = ptr_reg - MAP_MON_BASE;
    wire is_mon = (ptr_reg >= MAP_MON_BASE) && (mon_ofs < 8'(NUM_MON));
    wire is_live = is_mon || ptr_reg == MAP_ALARM || ptr_reg == MAP_WARN;
    wire [7:0] rd_byte = is_mon ? mon[mon_ofs[2:0]] :
                         (ptr_reg == MAP_ALARM) ? 8'(alarm_w) :
                         (ptr_reg == MAP_WARN) ? 8'(warn_w) : mem[ptr_reg]; // see [R13] [R12]
    wire byte_in = (cnt_reg == 4'h8);
    wire addr_hit = (shift_reg[7:1] == DEV_ADDR);
    wire mem_we = scl_fall && st_reg == OMM_WDAT && byte_in && (ptr_reg < wp_limit) && !is_live; // see [R9]
    wire rx_state = (st_reg == OMM_DEV) || (st_reg == OMM_WADR) || (st_reg == OMM_WDAT);
    wire load_rd = scl_fall && ((st_reg == OMM_ACKD && rw_reg) || st_reg == OMM_RACK);
    wire sel = !desel_s;

    // Management memory
    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem[ptr_reg] <= shift_reg; // see [R9]
        end
    end

    // Serial slave sequencer
    always_ff @(posedge clk) begin
        if (core_rst || !sel || i2c_stop) begin
            st_reg <= OMM_IDLE; // see [R1] [R6]
            cnt_reg <= 4'h0;
            sda_oe_reg <= 1'b0;
            if (core_rst) begin
                ptr_reg <= 8'h00;
                rw_reg <= 1'b0;
                shift_reg <= 8'h00;
                tx_reg <= 8'h00;
            end
        end else if (i2c_start) begin
            st_reg <= OMM_DEV;
            cnt_reg <= 4'h0;
            sda_oe_reg <= 1'b0;
        end else if (scl_rise) begin
            if (rx_state) begin
                shift_reg <= {shift_reg[6:0], sda_s}; // see [R9]
                cnt_reg <= cnt_reg + 4'h1;
            end else if (st_reg == OMM_RACK && sda_s) begin
                st_reg <= OMM_IDLE;
            end
        end else if (load_rd) begin
            tx_reg <= rd_byte; // see [R10]
            sda_oe_reg <= !rd_byte[7];
            ptr_reg <= ptr_reg + 8'h01; // see [R12]
            cnt_reg <= 4'h1;
            st_reg <= OMM_RDAT;
        end else if (scl_fall) begin
            case (st_reg)
                OMM_DEV: begin
                    if (byte_in) begin
                        cnt_reg <= 4'h0;
                        rw_reg <= shift_reg[0];
                        sda_oe_reg <= addr_hit;
                        st_reg <= addr_hit ? OMM_ACKD : OMM_IDLE;
                    end
                end
                OMM_ACKD: begin
                    sda_oe_reg <= 1'b0;
                    st_reg <= OMM_WADR;
                end
                OMM_WADR: begin
                    if (byte_in) begin
                        ptr_reg <= shift_reg; // see [R12]
                        sda_oe_reg <= 1'b1;
                        st_reg <= OMM_ACKW;
                    end
                end
                OMM_WDAT: begin
                    if (byte_in) begin
                        ptr_reg <= ptr_reg + 8'h01; // see [R12]
                        sda_oe_reg <= 1'b1;
                        st_reg <= OMM_ACKW;
                    end
                end
                OMM_ACKW: begin
                    sda_oe_reg <= 1'b0;
                    cnt_reg <= 4'h0;
                    st_reg <= OMM_WDAT;
                end
                OMM_RDAT: begin
                    if (byte_in) begin
                        sda_oe_reg <= 1'b0; // see [R10]
                        cnt_reg <= 4'h0;
                        st_reg <= OMM_RACK;
                    end else begin
                        sda_oe_reg <= !tx_reg[6]; // see [R10]
                        tx_reg <= {tx_reg[6:0], 1'b0};
                        cnt_reg <= cnt_reg + 4'h1;
                    end
                end
                default: begin
                    st_reg <= st_reg;
                end
            endcase
        end
    end

    // Pin drivers, open collector
    logic laser_reg;
    logic standby_reg;
    logic int_oe_reg;
    logic nr_oe_reg;
    logic los_oe_reg;
    logic pres_oe_reg;
    always_ff @(posedge clk) begin
        if (core_rst) begin
            laser_reg <= 1'b0;
            standby_reg <= 1'b0;
            int_oe_reg <= 1'b0;
            nr_oe_reg <= 1'b0;
            los_oe_reg <= 1'b0;
            pres_oe_reg <= 1'b1;
        end else begin
            laser_reg <= !txdis_s && !pd_s && init_done; // see [R3] [R17] [R5]
            standby_reg <= pd_s; // see [R5]
            int_oe_reg <= |(status_reg & mask_reg); // see [R2] [R7]
            nr_oe_reg <= init_done && !pd_s; // see [R18] [R7]
            los_oe_reg <= !los_s; // see [R15] [R16]
            pres_oe_reg <= 1'b1; // see [R4]
        end
    end

    // Outputs
    assign avs_readdata = rdata_reg;
    assign avs_waitrequest = wait_reg;
    assign irq = irq_reg;
    assign sda_o = 1'b0; // see [R7]
    assign sda_oe = sda_oe_reg;
    assign laser_enable = laser_reg;
    assign standby = standby_reg;
    assign int_n_o = 1'b0;
    assign int_n_oe = int_oe_reg;
    assign presence_o = 1'b0;
    assign presence_oe = pres_oe_reg;
    assign not_ready_flag_o = 1'b0;
    assign not_ready_flag_oe = nr_oe_reg;
    assign rx_signal_lost_o = 1'b0;
    assign rx_signal_lost_oe = los_oe_reg;

    // Checks
    property p_desel_quiet;
        @(posedge clk) disable iff (reset) desel_s |=> !sda_oe && st_reg == OMM_IDLE;
    endproperty
    a_desel_quiet: assert property (p_desel_quiet) else $error("slave active while deselected"); // see [R1]
    property p_int_pin;
        @(posedge clk) disable iff (core_rst) (|(status_reg & mask_reg)) |=> int_n_oe && irq;
    endproperty
    a_int_pin: assert property (p_int_pin) else $error("interrupt not driven"); // see [R2]
    property p_laser_off;
        @(posedge clk) disable iff (reset) $rose(laser_off_request) |-> ##[1:TXOFF_BOUND] !laser_enable;
    endproperty
    a_laser_off: assert property (p_laser_off) else $error("laser still on after disable"); // see [R3] [R17]
    property p_presence;
        @(posedge clk) disable iff (core_rst) presence_oe && !presence_o;
    endproperty
    a_presence: assert property (p_presence) else $error("presence line not grounded"); // see [R4]
    property p_standby;
        @(posedge clk) disable iff (core_rst) pd_s |=> standby && !laser_enable && !not_ready_flag_oe;
    endproperty
    a_standby: assert property (p_standby) else $error("not in standby"); // see [R5]
    property p_pd_reset;
        @(posedge clk) disable iff (reset) pd_fall |=> ##1 st_reg == OMM_IDLE && init_cnt_reg == 16'h0000;
    endproperty
    a_pd_reset: assert property (p_pd_reset) else $error("power-down edge did not reset"); // see [R6]
    property p_open_drain;
        @(posedge clk) !sda_o && !int_n_o && !not_ready_flag_o && !rx_signal_lost_o;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("pin driven high"); // see [R7]
    property p_sda_fall;
        @(posedge clk) disable iff (core_rst) $rose(sda_oe) |-> $past(scl_fall) || $past(load_rd);
    endproperty
    a_sda_fall: assert property (p_sda_fall) else $error("data changed off clock fall"); // see [R10]
    property p_wp;
        @(posedge clk) disable iff (core_rst)
            (scl_fall && st_reg == OMM_WDAT && byte_in && ptr_reg >= wp_limit) |=> mem[$past(ptr_reg)] == $past(rd_byte);
    endproperty
    a_wp: assert property (p_wp) else $error("protected byte written"); // see [R9]
    property p_incr;
        @(posedge clk) disable iff (core_rst || !sel)
            (scl_fall && st_reg == OMM_WDAT && byte_in && !i2c_start && !i2c_stop) |=> ptr_reg == $past(ptr_reg) + 8'h01;
    endproperty
    a_incr: assert property (p_incr) else $error("address did not advance"); // see [R12]
    property p_los;
        @(posedge clk) disable iff (core_rst) $changed(los_s) |=> rx_signal_lost_oe == !$past(los_s);
    endproperty
    a_los: assert property (p_los) else $error("loss-of-signal pin wrong"); // see [R15] [R16]
    property p_alarm;
        @(posedge clk) disable iff (core_rst) alarm_w[0] |=> status_reg[ST_ALARM_LSB];
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm not latched"); // see [R14]
    property p_not_ready;
        @(posedge clk) disable iff (reset) !init_done |=> !not_ready_flag_oe;
    endproperty
    a_not_ready: assert property (p_not_ready) else $error("ready before init"); // see [R18]
endmodule : omm_core

// ### tb/omm_host.sv
// Host board model: 2-wire serial master, lines pulled up on the board.
// Assumes the bench resolves the data wire from every pull-down.
`timescale 1ns/100ps
module omm_host (
    output logic scl, // Serial clock, host driven
    output logic sda_pull, // Host pulls data low
    input wire logic sda // Resolved data wire
);
    // Lines idle high; clock stands still between frames
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // One bit: data set while clock low, sampled late in the high phase
    task bit_io(input logic b, output logic r);
        #20 sda_pull = !b;
        #180 scl = 1'b1;
        #150 r = sda;
        #50 scl = 1'b0;
    endtask : bit_io
    // Start or repeated start
    task start;
        #200 sda_pull = 1'b0;
        #200 scl = 1'b1;
        #200 sda_pull = 1'b1;
        #200 scl = 1'b0;
    endtask : start
    // Stop, then bus free
    task stop;
        #20 sda_pull = 1'b1;
        #180 scl = 1'b1;
        #200 sda_pull = 1'b0;
        #200;
    endtask : stop
    // Byte out, MSB first, then the slave's ack
    task wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask : wbyte
    // Byte in; last byte gets a not-ack
    task rbyte(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 0; i < 8; i++) begin
            bit_io(1'b1, r);
            b = {b[6:0], r};
        end
        bit_io(last, r);
    endtask : rbyte
endmodule : omm_host

// ### tb/omm_core_test.sv
// Testbench of the optical module management block: pins, register bus, interrupt, serial memory.
// Assumes the host model beside it and pull-ups on every open-collector line.
`timescale 1ns/100ps
module omm_core_test;
    import omm_pkg::*;
    typedef struct packed {logic loff, pd, dark, laser, stby, los_oe, nr_oe;} omm_row_s;
    logic clk = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic [5:0] avs_address = '0;
    logic [31:0] avs_writedata = '0, avs_readdata, q;
    logic avs_waitrequest, irq, scl, sda_pull, sda_oe, laser_enable, standby, int_n_oe;
    logic presence_oe, not_ready_flag_oe, rx_signal_lost_oe, ack;
    logic mod_desel_n = 1'b0, laser_off_request = 1'b0, pdown_rst = 1'b0, rx_no_light = 1'b0;
    logic [7:0] b0, b1, mon_temp = 8'h20;
    logic [3:0] avs_byteenable = 4'hf;
    int failures = 0, cmp_count = 0;
    omm_row_s rows [5] = '{7'b0001011, 7'b1000011, 7'b0011001, 7'b0100110, 7'b0001011};
    wire sda = !(sda_pull | sda_oe);
    // Clock
    always #25 clk = !clk;
    omm_core #(.INIT_CYC(4)) omm_core_i (.clk(clk), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq), .scl_i(scl), .sda_i(sda),
        .sda_o(), .sda_oe(sda_oe), .mod_desel_n(mod_desel_n), .laser_off_request(laser_off_request),
        .pdown_rst(pdown_rst), .rx_no_light(rx_no_light), .mon_temp(mon_temp), .mon_bias(8'h80),
        .mon_txpwr(8'h80), .mon_rxpwr(8'h80), .mon_vcc(8'h80), .laser_enable(laser_enable),
        .standby(standby), .int_n_o(), .int_n_oe(int_n_oe), .presence_o(), .presence_oe(presence_oe),
        .not_ready_flag_o(), .not_ready_flag_oe(not_ready_flag_oe), .rx_signal_lost_o(),
        .rx_signal_lost_oe(rx_signal_lost_oe));
    omm_host omm_host_i (.scl(scl), .sda_pull(sda_pull), .sda(sda));
    // Verdict and end of run
    task conclude;
        if (failures == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude
    // Compare a single bit
    task chk_bit(input logic got, input logic exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %0t %s got %b", $time, what, got);
        end
    endtask : chk_bit
    // Compare a word
    task chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %0t %s got %h", $time, what, got);
        end
    endtask : chk_word
    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    // One bus access, held until waitrequest is seen low
    task av(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk);
        avs_write <= w;
        avs_read <= !w;
        avs_address <= a;
        avs_writedata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        r = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 50) begin
            failures++;
            conclude();
        end
    endtask : av
    // Serial write of pointer and two bytes
    task sw(input logic [7:0] p, input logic [7:0] d0, input logic [7:0] d1);
        omm_host_i.start();
        omm_host_i.wbyte({DEV_ADDR_DEFAULT, 1'b0}, ack);
        chk_bit(ack, 1'b1, "addr ack");
        omm_host_i.wbyte(p, ack);
        omm_host_i.wbyte(d0, ack);
        omm_host_i.wbyte(d1, ack);
        omm_host_i.stop();
    endtask : sw
    // Random read of two bytes from a pointer
    task sr(input logic [7:0] p);
        omm_host_i.start();
        omm_host_i.wbyte({DEV_ADDR_DEFAULT, 1'b0}, ack);
        omm_host_i.wbyte(p, ack);
        omm_host_i.start();
        omm_host_i.wbyte({DEV_ADDR_DEFAULT, 1'b1}, ack);
        omm_host_i.rbyte(1'b0, b0);
        omm_host_i.rbyte(1'b1, b1);
        omm_host_i.stop();
    endtask : sr
    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        chk_bit(not_ready_flag_oe, 1'b0, "not ready");
        foreach (rows[i]) begin
            laser_off_request <= rows[i].loff;
            pdown_rst <= rows[i].pd;
            rx_no_light <= rows[i].dark;
            cyc(200);
            chk_bit(laser_enable, rows[i].laser, "laser");
            chk_bit(standby, rows[i].stby, "standby");
            chk_bit(rx_signal_lost_oe, rows[i].los_oe, "los");
            chk_bit(not_ready_flag_oe, rows[i].nr_oe, "ready");
            chk_bit(presence_oe, 1'b1, "presence");
        end
        av(1'b1, OFS_MASK, 32'h0000_0801, q);
        laser_off_request <= 1'b1;
        cyc(20);
        chk_bit(int_n_oe, 1'b1, "int pin");
        laser_off_request <= 1'b0;
        av(1'b1, OFS_STATUS, 32'h0000_0800, q);
        cyc(4);
        chk_bit(int_n_oe, 1'b0, "int clear");
        av(1'b1, OFS_THR0, 32'hffff_6050, q);
        cyc(10);
        av(1'b0, OFS_STATUS, 32'h0, q);
        chk_word(q & 32'h0000_0021, 32'h0000_0021, "alarm");
        chk_bit(irq, 1'b1, "alarm irq");
        sr(MAP_MON_BASE);
        chk_word({16'h0, b0, b1}, 32'h0000_2080, "monitor");
        // Temperature between alarm and warning limits: warning flag only
        @(posedge clk);
        mon_temp <= 8'h55;
        sr(MAP_ALARM);
        chk_word({16'h0, b0, b1}, 32'h0000_0001, "live flags");
        av(1'b0, 6'h3c, 32'h0, q);
        chk_word(q, 32'h0, "unmapped");
        sw(8'h10, 8'ha5, 8'h3c);
        sr(8'h10);
        chk_word({16'h0, b0, b1}, 32'h0000_a53c, "memory");
        av(1'b1, OFS_CTRL, 32'h0000_0010, q);
        sw(8'h10, 8'h00, 8'h00);
        sr(8'h10);
        chk_word({16'h0, b0, b1}, 32'h0000_a53c, "protected");
        @(posedge clk);
        mod_desel_n <= 1'b1;
        omm_host_i.start();
        omm_host_i.wbyte({DEV_ADDR_DEFAULT, 1'b0}, ack);
        omm_host_i.stop();
        chk_bit(ack, 1'b0, "deselected");
        @(posedge clk);
        mod_desel_n <= 1'b0;
        pdown_rst <= 1'b1;
        cyc(10);
        pdown_rst <= 1'b0;
        cyc(20);
        av(1'b0, OFS_CTRL, 32'h0, q);
        chk_word(q, CTRL_RESET, "ctrl reset");
        chk_bit(irq, 1'b0, "irq reset");
        // Only lane 1 enabled: low byte keeps its reset value
        avs_byteenable <= 4'h2;
        av(1'b1, OFS_CTRL, 32'h0000_5511, q);
        avs_byteenable <= 4'hf;
        av(1'b0, OFS_CTRL, 32'h0, q);
        chk_word(q, 32'h0000_5580, "lane write");
        conclude();
    end
endmodule : omm_core_test
